// ---- logic/via_cfg.svh ----
/*
 * Constants for the vectored interrupt arbiter: register addresses,
 * field positions, reset values, vector layout and cycle counts.
 * Assumes it is included by bare name from the arbiter sources.
 */
`ifndef VIA_CFG_SVH
`define VIA_CFG_SVH

// ============================================================
// Register addresses
`define VIA_ADDR_ENA 8'hA8
`define VIA_ADDR_PRI 8'hB8
`define VIA_ADDR_XENA1 8'hE6
`define VIA_ADDR_XPRI1 8'hF6
`define VIA_ADDR_XENA2 8'hE7
`define VIA_ADDR_XPRI2 8'hF7

// ============================================================
// Fields and reset values
`define VIA_GLOBAL_EN_BIT 7
`define VIA_RESET_BYTE 8'h00
`define VIA_PRI_UNUSED_ONE 8'h80
`define VIA_UNMAPPED_READ 8'h00

// ============================================================
// Sources and vectors
`define VIA_NSRC 18
`define VIA_SRC_UART 4
`define VIA_SRC_TIMER2 5
`define VIA_SRC_SPI 6
`define VIA_SRC_PCA 10
`define VIA_SRC_ABSENT 16
`define VIA_HWCLR_SRCS 4
`define VIA_VEC_BASE 16'h0003
`define VIA_RESET_VECTOR 16'h0000

// ============================================================
// Cycle counts
`define VIA_DETECT_CYCLES 1
`define VIA_LCALL_CYCLES 4
`define VIA_RETI_CYCLES 5
`define VIA_DIV_CYCLES 8
`define VIA_MIN_LATENCY (`VIA_DETECT_CYCLES + `VIA_LCALL_CYCLES)
`define VIA_MAX_LATENCY (`VIA_DETECT_CYCLES + `VIA_RETI_CYCLES + `VIA_DIV_CYCLES + `VIA_LCALL_CYCLES)

`endif

// ---- logic/via_pkg.sv ----
/*
 * Types shared by the vectored interrupt arbiter.
 * Assumes nothing of its surroundings.
 */
package via_pkg;

	// ============================================================
	// Sequencer states, one-hot.
	typedef enum logic [1:0] {
		VIA_ST_IDLE = 2'h1,
		VIA_ST_CALL = 2'h2
	} via_state_t;

endpackage : via_pkg

// ---- logic/via_prio_pick.sv ----
/*
 * Fixed-order, two-level priority picker for the interrupt arbiter.
 * Assumes requests are already masked; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module via_prio_pick #(
	parameter int N = 18,
	parameter int IW = 5
) (
	input wire logic [N-1:0] req_i,
	input wire logic [N-1:0] high_i,
	input wire logic allow_low_i,
	input wire logic allow_high_i,
	output logic valid_o,
	output logic [IW-1:0] idx_o,
	output logic level_o
);

	// ============================================================
	// Scan from the top order down so the lowest order number is left standing.
	always_comb begin
		logic found_hi;
		logic found_lo;
		logic [IW-1:0] idx_hi;
		logic [IW-1:0] idx_lo;
		found_hi = 1'b0;
		found_lo = 1'b0;
		idx_hi = '0;
		idx_lo = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req_i[i] && high_i[i]) begin
				found_hi = 1'b1;
				idx_hi = IW'(i);
			end
			if (req_i[i] && !high_i[i]) begin
				found_lo = 1'b1;
				idx_lo = IW'(i);
			end
		end
		// The high level beats the low level whenever both may run.
		if (found_hi && allow_high_i) begin
			valid_o = 1'b1;
			idx_o = idx_hi;
			level_o = 1'b1;
		end else begin
			valid_o = found_lo && allow_low_i;
			idx_o = idx_lo;
			level_o = 1'b0;
		end
	end

endmodule : via_prio_pick

`default_nettype wire

// ---- logic/via_top.sv ----
/*
 * Vectored interrupt arbiter: enable and priority registers on the
 * special-function bus, masking, two-level fixed-order arbitration and
 * the call request with vector address to the CPU sequencer.
 * Assumes the CPU reports instruction boundaries and return completion
 * on single-cycle pulses and that all inputs are synchronous to ref_clk_i.
 */
// Function
// - Pending requests are sampled and arbitrated in every clock cycle.
// - A request can reach the CPU as a call one clock after it rises, then the call takes four.
// - With a request pending at a return, one more instruction completes before the call.
// - The worst response is eighteen clocks: detect, return, divide, then the call.
// - A request is held off while an equal or higher level routine runs until its return.
// - Each source vectors to 0x0003 plus eight times its order; reset vectors to 0x0000.
// - Several flags of one source are ORed; orders 0 to 3 are cleared by hardware on the call.
// - The global enable bit 7 gates every source; with it set each source follows its mask.
// - Enable bits 0 to 6 mask orders 0 to 6; a zero blocks that source.
// - With the timer 2 mask set, either timer 2 overflow flag raises the request.
// - The enable register sits at 0xA8 on every page, is bit-writable and resets to zero.
// - A high-level request preempts a low-level routine; a high-level routine is never preempted.
// - Simultaneous requests go to the higher level, then to the lower order number.
// - A flag left set after a return raises a fresh request at once.
`timescale 1ns/1ps
`default_nettype none
`include "via_cfg.svh"

module via_top #(
	parameter int NSRC = `VIA_NSRC,
	parameter int IW = 5
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [2:0] sfr_bit_sel_i,
	input wire logic sfr_bit_val_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic [NSRC-1:0] src_flag_i,
	input wire logic [1:0] uart_flag_i,
	input wire logic timer2_low_overflow_flag_i,
	input wire logic timer2_high_overflow_flag_i,
	input wire logic [3:0] serial_periph_flag_i,
	input wire logic counter_array_overflow_flag_i,
	input wire logic [5:0] capture_module_flag_i,
	input wire logic pwm_cycle_overflow_flag_i,
	input wire logic cpu_boundary_i,
	input wire logic cpu_reti_done_i,
	output logic irq_call_o,
	output logic [15:0] irq_vector_o,
	output logic irq_level_o,
	output logic [`VIA_HWCLR_SRCS-1:0] hw_clear_o,
	output logic [1:0] svc_active_o
);

	// ============================================================
	// Register file
	logic [7:0] interrupt_enable_mask_reg, interrupt_enable_mask_next;
	logic [7:0] base_priority_reg, base_priority_next;
	logic [7:0] extended_enable_reg1_reg, extended_enable_reg1_next;
	logic [7:0] extended_priority_reg1_reg, extended_priority_reg1_next;
	logic [7:0] extended_enable_reg2_reg, extended_enable_reg2_next;
	logic [7:0] extended_priority_reg2_reg, extended_priority_reg2_next;
	logic [7:0] rdata_next;

	// Apply a byte write or a single-bit write aimed at one address.
	function automatic logic [7:0] via_upd(input logic [7:0] cur, input logic [7:0] addr);
		logic [7:0] v;
		v = cur;
		if (sfr_addr_i == addr && sfr_wr_i) begin
			v = sfr_wdata_i;
		end else if (sfr_addr_i == addr && sfr_bit_wr_i) begin
			v[sfr_bit_sel_i] = sfr_bit_val_i;
		end
		return v;
	endfunction : via_upd

	// Next register values and read data; the page select plays no part in decode.
	always_comb begin
		interrupt_enable_mask_next = via_upd(interrupt_enable_mask_reg, `VIA_ADDR_ENA);
		base_priority_next = via_upd(base_priority_reg, `VIA_ADDR_PRI);
		extended_enable_reg1_next = via_upd(extended_enable_reg1_reg, `VIA_ADDR_XENA1);
		extended_priority_reg1_next = via_upd(extended_priority_reg1_reg, `VIA_ADDR_XPRI1);
		extended_enable_reg2_next = via_upd(extended_enable_reg2_reg, `VIA_ADDR_XENA2);
		extended_priority_reg2_next = via_upd(extended_priority_reg2_reg, `VIA_ADDR_XPRI2);
		case (sfr_addr_i)
			`VIA_ADDR_ENA: rdata_next = interrupt_enable_mask_reg;
			`VIA_ADDR_PRI: rdata_next = base_priority_reg | `VIA_PRI_UNUSED_ONE;
			`VIA_ADDR_XENA1: rdata_next = extended_enable_reg1_reg;
			`VIA_ADDR_XPRI1: rdata_next = extended_priority_reg1_reg;
			`VIA_ADDR_XENA2: rdata_next = extended_enable_reg2_reg;
			`VIA_ADDR_XPRI2: rdata_next = extended_priority_reg2_reg;
			default: rdata_next = `VIA_UNMAPPED_READ;
		endcase
	end

	// Register the file; everything clears to zero on reset.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			interrupt_enable_mask_reg <= `VIA_RESET_BYTE;
			base_priority_reg <= `VIA_RESET_BYTE;
			extended_enable_reg1_reg <= `VIA_RESET_BYTE;
			extended_priority_reg1_reg <= `VIA_RESET_BYTE;
			extended_enable_reg2_reg <= `VIA_RESET_BYTE;
			extended_priority_reg2_reg <= `VIA_RESET_BYTE;
			sfr_rdata_o <= `VIA_RESET_BYTE;
		end else begin
			interrupt_enable_mask_reg <= interrupt_enable_mask_next;
			base_priority_reg <= base_priority_next;
			extended_enable_reg1_reg <= extended_enable_reg1_next;
			extended_priority_reg1_reg <= extended_priority_reg1_next;
			extended_enable_reg2_reg <= extended_enable_reg2_next;
			extended_priority_reg2_reg <= extended_priority_reg2_next;
			sfr_rdata_o <= rdata_next;
		end
	end

	// ============================================================
	// Request gathering and masking
	logic [NSRC-1:0] raw_req;
	logic [NSRC-1:0] src_enable;
	logic [NSRC-1:0] src_high;
	logic [NSRC-1:0] masked_req;

	// Fold multi-flag sources into one request line; order 16 has no source.
	always_comb begin
		raw_req = src_flag_i;
		raw_req[`VIA_SRC_UART] = |uart_flag_i;
		raw_req[`VIA_SRC_TIMER2] = timer2_low_overflow_flag_i | timer2_high_overflow_flag_i;
		raw_req[`VIA_SRC_SPI] = |serial_periph_flag_i;
		raw_req[`VIA_SRC_PCA] = counter_array_overflow_flag_i | (|capture_module_flag_i)
			| pwm_cycle_overflow_flag_i;
		raw_req[`VIA_SRC_ABSENT] = 1'b0;
	end

	// Per-source enables and levels: base bits for orders 0-6, extended bits above.
	assign src_enable = {extended_enable_reg2_reg[2:0], extended_enable_reg1_reg,
		interrupt_enable_mask_reg[6:0]};
	assign src_high = {extended_priority_reg2_reg[2:0], extended_priority_reg1_reg,
		base_priority_reg[6:0]};
	// Live flags are masked every cycle, so a flag left set after a return asks again at once.
	assign masked_req = raw_req & src_enable
		& {NSRC{interrupt_enable_mask_reg[`VIA_GLOBAL_EN_BIT]}};

	// ============================================================
	// Arbitration
	logic act_hi_reg, act_hi_next;
	logic act_lo_reg, act_lo_next;
	logic win_valid;
	logic [IW-1:0] win_idx;
	logic win_level;

	// Nothing preempts a high routine; a low routine yields only to high requests.
	via_prio_pick #(
		.N(NSRC),
		.IW(IW)
	) u_pick (
		.req_i(masked_req),
		.high_i(src_high),
		.allow_low_i(!act_hi_reg && !act_lo_reg),
		.allow_high_i(!act_hi_reg),
		.valid_o(win_valid),
		.idx_o(win_idx),
		.level_o(win_level)
	);

	// ============================================================
	// Call sequencer
	via_pkg::via_state_t state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [IW-1:0] idx_reg, idx_next;
	logic call_next;
	logic [15:0] vector_next;
	logic level_next;
	logic [`VIA_HWCLR_SRCS-1:0] hwclr_next;
	logic take;

	// A call is issued at a boundary, never at the one that ends a return.
	assign take = (state_reg == via_pkg::VIA_ST_IDLE) && cpu_boundary_i && !cpu_reti_done_i
		&& win_valid;

	// Next values of the sequencer, level tracking and call outputs.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		act_hi_next = act_hi_reg;
		act_lo_next = act_lo_reg;
		call_next = 1'b0;
		vector_next = irq_vector_o;
		level_next = irq_level_o;
		hwclr_next = '0;
		// A completed return drops the level that was last entered.
		if (cpu_reti_done_i) begin
			if (act_hi_reg) begin
				act_hi_next = 1'b0;
			end else begin
				act_lo_next = 1'b0;
			end
		end
		case (state_reg)
			via_pkg::VIA_ST_IDLE: begin
				if (take) begin
					call_next = 1'b1;
					idx_next = win_idx;
					vector_next = `VIA_VEC_BASE + {8'h00, win_idx, 3'h0};
					level_next = win_level;
					if (win_level) begin
						act_hi_next = 1'b1;
					end else begin
						act_lo_next = 1'b1;
					end
					for (int i = 0; i < `VIA_HWCLR_SRCS; i++) begin
						hwclr_next[i] = (win_idx == IW'(i));
					end
					state_next = via_pkg::VIA_ST_CALL;
					cnt_next = 3'(`VIA_LCALL_CYCLES - 1);
				end
			end
			via_pkg::VIA_ST_CALL: begin
				// The CPU spends the long call here; no second call may start.
				if (cnt_reg == 3'h0) begin
					state_next = via_pkg::VIA_ST_IDLE;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			default: begin
				state_next = via_pkg::VIA_ST_IDLE;
			end
		endcase
	end

	// Register the sequencer; the output vector resets to the reset vector and holds the last call's vector between calls.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= via_pkg::VIA_ST_IDLE;
			cnt_reg <= 3'h0;
			idx_reg <= '0;
			act_hi_reg <= 1'b0;
			act_lo_reg <= 1'b0;
			irq_call_o <= 1'b0;
			irq_vector_o <= `VIA_RESET_VECTOR;
			irq_level_o <= 1'b0;
			hw_clear_o <= '0;
			svc_active_o <= 2'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			act_hi_reg <= act_hi_next;
			act_lo_reg <= act_lo_next;
			irq_call_o <= call_next;
			irq_vector_o <= vector_next;
			irq_level_o <= level_next;
			hw_clear_o <= hwclr_next;
			svc_active_o <= {act_hi_next, act_lo_next};
		end
	end

	// ============================================================
	// Checks
	localparam int WORST = `VIA_MAX_LATENCY;

	default clocking via_cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_call;
		irq_call_o;
	endsequence
	sequence s_lcall_quiet;
		!irq_call_o [*4];
	endsequence

	chk_call_spacing: assert property (s_call |=> s_lcall_quiet)
		else $error("Second call issued during the long call.");
	chk_global_gate: assert property (irq_call_o |-> $past(interrupt_enable_mask_reg[7]))
		else $error("Call issued with global enable clear.");
	chk_vector_math: assert property (irq_call_o |-> irq_vector_o == 16'h0003 + {8'h00, idx_reg, 3'h0})
		else $error("Vector does not match the winning order.");
	chk_reti_next_insn: assert property (cpu_reti_done_i |=> !irq_call_o)
		else $error("Call issued on the boundary of a return.");
	chk_high_no_preempt: assert property (act_hi_reg && !cpu_reti_done_i |=> !irq_call_o)
		else $error("High routine preempted.");
	chk_equal_level_hold: assert property (irq_call_o && $past(act_lo_reg) |-> irq_level_o)
		else $error("Low request entered over a running low routine.");
	chk_hw_clear_pulse: assert property (irq_call_o && idx_reg < 5'd4 |-> hw_clear_o == 4'h1 << idx_reg)
		else $error("Hardware clear missing for a vectored source.");
	chk_mask_bit_write: assert property (sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == 8'hA8
		|=> interrupt_enable_mask_reg[$past(sfr_bit_sel_i)] == $past(sfr_bit_val_i))
		else $error("Bit write to the enable register lost.");
	chk_fast_response: assert property ($rose(masked_req[0]) && cpu_boundary_i && !cpu_reti_done_i
		&& state_reg == via_pkg::VIA_ST_IDLE && !act_hi_reg && !act_lo_reg && src_high == '0
		|=> irq_call_o)
		else $error("Newly raised request not answered on the next clock.");
	chk_worst_bound: assert property (cpu_reti_done_i ##1 win_valid |-> ##[1:WORST] irq_call_o)
		else $error("Pending request not called within the worst latency.");

endmodule : via_top

`default_nettype wire

// ---- verification/via_cpu_model.sv ----
/*
 * Behavioural CPU sequencer facing the interrupt arbiter: reports
 * instruction boundaries, occupies itself during a call and runs returns.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module via_cpu_model (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic irq_call_i,
	input wire logic ret_cmd_i,
	input wire logic [3:0] insn_len_i,
	output logic boundary_o,
	output logic reti_done_o
);
	// ============================================================
	// Instruction timing
	logic [3:0] cnt_reg;
	logic ret_pend_reg;
	logic in_reti_reg;

	// Boundaries come only between instructions, never inside a call.
	assign boundary_o = (cnt_reg == 4'h0) && !irq_call_i;
	assign reti_done_o = boundary_o && in_reti_reg;

	// A call holds the sequencer four cycles; a return takes five.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_reg <= 4'h0;
			ret_pend_reg <= 1'b0;
			in_reti_reg <= 1'b0;
		end else if (irq_call_i) begin
			cnt_reg <= 4'h2;
			in_reti_reg <= 1'b0;
		end else begin
			if (ret_cmd_i) begin
				ret_pend_reg <= 1'b1;
			end
			if (boundary_o) begin
				in_reti_reg <= ret_pend_reg;
				if (ret_pend_reg) begin
					cnt_reg <= 4'h4;
					ret_pend_reg <= 1'b0;
				end else begin
					cnt_reg <= insn_len_i - 4'h1;
				end
			end else begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule : via_cpu_model

`default_nettype wire

// ---- verification/via_top_tb.sv ----
/*
 * Self-checking bench for the interrupt arbiter with random sources.
 * Assumes the CPU sequencer model beside it and the shared constants.
 */
`timescale 1ns/1ps
`default_nettype none
`include "via_cfg.svh"

module via_top_tb;
	// ============================================================
	// Signals
	logic ref_clk_i, rst_b_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, rv;
	logic [2:0] sfr_bit_sel_i;
	logic [`VIA_NSRC-1:0] src_flag_i, en;
	logic [1:0] uart_flag_i, svc_active_o;
	logic t2l, t2h, pca_ovf, pwm_ov, ret_cmd, bnd, reti, irq_call_o, irq_level_o;
	logic [3:0] spi_f, insn_len, hw_clear_o;
	logic [5:0] cap_f;
	logic [15:0] irq_vector_o;
	int miscompares, cmp_count, gap, k, a, b, h;

	via_top i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i),
		.sfr_bit_sel_i(sfr_bit_sel_i), .sfr_bit_val_i(sfr_bit_val_i),
		.sfr_rdata_o(sfr_rdata_o), .src_flag_i(src_flag_i), .uart_flag_i(uart_flag_i),
		.timer2_low_overflow_flag_i(t2l), .timer2_high_overflow_flag_i(t2h),
		.serial_periph_flag_i(spi_f), .counter_array_overflow_flag_i(pca_ovf),
		.capture_module_flag_i(cap_f), .pwm_cycle_overflow_flag_i(pwm_ov),
		.cpu_boundary_i(bnd), .cpu_reti_done_i(reti), .irq_call_o(irq_call_o),
		.irq_vector_o(irq_vector_o), .irq_level_o(irq_level_o),
		.hw_clear_o(hw_clear_o), .svc_active_o(svc_active_o));

	via_cpu_model i_cpu (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .irq_call_i(irq_call_o),
		.ret_cmd_i(ret_cmd), .insn_len_i(insn_len), .boundary_o(bnd), .reti_done_o(reti));

	// ============================================================
	// Helpers
	task automatic check(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : check

	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task idle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : idle

	task wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge ref_clk_i);
		sfr_addr_i <= ad;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		sfr_wr_i <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge ref_clk_i);
		sfr_addr_i <= ad;
		idle(1);
		d = sfr_rdata_o;
	endtask : rd

	task set_regs(input logic [17:0] e, input logic [17:0] p, input logic ea);
		wr(`VIA_ADDR_ENA, {ea, e[6:0]});
		wr(`VIA_ADDR_PRI, {1'b0, p[6:0]});
		wr(`VIA_ADDR_XENA1, e[14:7]);
		wr(`VIA_ADDR_XPRI1, p[14:7]);
		wr(`VIA_ADDR_XENA2, {5'h00, e[17:15]});
		wr(`VIA_ADDR_XPRI2, {5'h00, p[17:15]});
	endtask : set_regs

	// Sets one of the flags of order n, picking a sub-flag at random; no timing.
	task raise(input int n);
		case (n)
			4: uart_flag_i[$urandom % 2] <= 1'b1;
			5: if ($urandom % 2) t2l <= 1'b1; else t2h <= 1'b1;
			6: spi_f[$urandom % 4] <= 1'b1;
			10: case ($urandom % 3) 0: pca_ovf <= 1'b1; 1: cap_f[$urandom % 6] <= 1'b1;
				default: pwm_ov <= 1'b1; endcase
			default: src_flag_i[n] <= 1'b1;
		endcase
	endtask : raise

	task fl(input int n, input logic v);
		@(posedge ref_clk_i);
		src_flag_i[n] <= v;
		#1;
	endtask : fl

	task clr;
		@(posedge ref_clk_i);
		{src_flag_i, uart_flag_i, t2l, t2h, spi_f, pca_ovf, cap_f, pwm_ov} <= '0;
		#1;
	endtask : clr

	task wait_call(input int mx, output int n);
		n = 0;
		while (irq_call_o !== 1'b1 && n < mx) begin
			idle(1);
			n++;
		end
	endtask : wait_call

	// Waits for a call and checks vector, level and hardware clear.
	task serve(input int n, input logic hi, input int mx, output int c);
		wait_call(mx, c);
		check(irq_call_o === 1'b1, "no call");
		check(irq_vector_o === `VIA_VEC_BASE + 16'(8 * n), "vector");
		check(irq_level_o === hi, "level");
		check(hw_clear_o === ((n < 4) ? 4'(1 << n) : 4'h0), "hw clear");
	endtask : serve

	task do_ret;
		@(posedge ref_clk_i);
		ret_cmd <= 1'b1;
		@(posedge ref_clk_i);
		ret_cmd <= 1'b0;
		#1;
		for (int i = 0; i < 40 && reti !== 1'b1; i++) idle(1);
	endtask : do_ret

	task none(input int mx);
		wait_call(mx, k);
		check(irq_call_o !== 1'b1, "unexpected call");
	endtask : none

	function automatic int pick();
		int n;
		n = $urandom % 17;
		return (n == 16) ? 17 : n;
	endfunction : pick

	// ============================================================
	// Clock, call spacing monitor and watchdog
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end

	// Every pair of calls must leave room for the four-cycle call.
	always @(posedge ref_clk_i) begin
		gap++;
		if (irq_call_o === 1'b1) begin
			check(gap >= 5, "calls too close");
			gap = 0;
		end
	end

	initial begin
		#(8 * 30000);
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		give_verdict();
	end

	// ============================================================
	// Main sequence
	initial begin
		{sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, ret_cmd, sfr_addr_i, sfr_wdata_i} = '0;
		{src_flag_i, uart_flag_i, t2l, t2h, spi_f, pca_ovf, cap_f, pwm_ov} = '0;
		sfr_bit_sel_i = 3'h0;
		insn_len = 4'h1;
		miscompares = 0;
		cmp_count = 0;
		gap = 5;
		rst_b_i = 1'b0;
		void'($urandom(7));
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		#1;
		check({irq_call_o, irq_vector_o, hw_clear_o, svc_active_o} === '0, "reset");
		rd(`VIA_ADDR_ENA, rv);
		check(rv === 8'h00, "enable reset");
		rd(`VIA_ADDR_PRI, rv);
		check(rv === 8'h80, "priority reset");
		rd(8'h55, rv);
		check(rv === 8'h00, "unmapped read");
		h = $urandom;
		wr(`VIA_ADDR_ENA, 8'(h));
		rd(`VIA_ADDR_ENA, rv);
		check(rv === 8'(h), "enable readback");
		// Global enable off blocks everything; a bit write then lets it through.
		set_regs(18'h3FFFF, 18'h00000, 1'b0);
		fl(3, 1'b1);
		none(12);
		@(posedge ref_clk_i);
		sfr_addr_i <= `VIA_ADDR_ENA;
		{sfr_bit_wr_i, sfr_bit_sel_i, sfr_bit_val_i} <= {1'b1, 3'h7, 1'b1};
		@(posedge ref_clk_i);
		sfr_bit_wr_i <= 1'b0;
		serve(3, 1'b0, 6, k);
		clr;
		rd(`VIA_ADDR_ENA, rv);
		check(rv === 8'hFF, "bit write");
		do_ret;
		idle(3);
		// Every source alone, random level, from an idle CPU.
		for (int i = 0; i < 18; i++) if (i != 16) begin
			h = $urandom % 2;
			en = 18'(1) << i;
			set_regs(en, h ? en : 18'h0, 1'b1);
			@(posedge ref_clk_i);
			raise(i);
			#1;
			serve(i, 1'(h), 4, k);
			check(k == 1, "latency");
			check(svc_active_o === (h ? 2'h2 : 2'h1), "active level");
			clr;
			do_ret;
			idle(3);
			check(svc_active_o === 2'h0, "return level");
		end
		// Simultaneous pairs: order first, then level.
		repeat (4) begin
			a = pick();
			b = pick();
			if (a == b) b = (a == 0) ? 1 : 0;
			if (a > b) {a, b} = {b, a};
			en = (18'(1) << a) | (18'(1) << b);
			for (int p = 0; p < 2; p++) begin
				set_regs(en, p ? 18'(1) << b : 18'h0, 1'b1);
				@(posedge ref_clk_i);
				raise(a);
				raise(b);
				#1;
				serve(p ? b : a, 1'(p), 4, k);
				clr;
				do_ret;
				idle(3);
			end
		end
		// Nesting: low routine, low waits, high preempts, high waits.
		set_regs(18'h3FFFF, 18'h0000C, 1'b1);
		fl(0, 1'b1);
		serve(0, 1'b0, 4, k);
		fl(0, 1'b0);
		fl(1, 1'b1);
		none(10);
		fl(2, 1'b1);
		serve(2, 1'b1, 4, k);
		fl(2, 1'b0);
		check(svc_active_o === 2'h3, "nested");
		fl(3, 1'b1);
		none(10);
		do_ret;
		serve(3, 1'b1, 4, k);
		check(k == 2, "one instruction after return");
		fl(3, 1'b0);
		do_ret;
		none(10);
		do_ret;
		serve(1, 1'b0, 4, k);
		check(k == 2, "held request after return");
		clr;
		do_ret;
		// A flag left set re-enters after the next instruction.
		set_regs(18'h00010, 18'h0, 1'b1);
		@(posedge ref_clk_i);
		raise(4);
		#1;
		serve(4, 1'b0, 4, k);
		do_ret;
		serve(4, 1'b0, 4, k);
		check(k == 2, "re-entry");
		clr;
		do_ret;
		// Worst case: return followed by an eight-cycle instruction.
		insn_len <= 4'h8;
		set_regs(18'h00021, 18'h0, 1'b1);
		@(posedge ref_clk_i);
		raise(5);
		#1;
		serve(5, 1'b0, 12, k);
		fl(0, 1'b1);
		do_ret;
		serve(0, 1'b0, 12, k);
		check(k == 9, "worst latency");
		clr;
		do_ret;
		idle(20);
		give_verdict();
	end
endmodule : via_top_tb

`default_nettype wire
